// ==== verilog/dcd_decoder.sv ====
// Command decoder and mode register of an eight-bank DDR memory.
// Assumes command pins come straight from the board, so they are
// synchronised here; mode data and decoded commands go to the core.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`default_nettype none
// What this block does
// - Sample pins on rising edge; illegal stays low
// - Deselect acts as idle command
// - Decode write and maintenance pin pairs
// - Mode load captures eighteen address bits
// - Read picks bank and location
// - Write stores only unmasked portions
// - Renew refreshes bank, ignores address
// - Five latency configurations from mode
// - Write latency equals read plus one
// - Burst length sets used address width
// - Burst change may spoil earlier data
// - Align reset bit low stops loop
// - Address mux takes two halves
// - Write data at write latency
module dcd_decoder
   import dcd_pkg::*;
#(
   parameter int LOCK_CLOCKS = LOCK_CYC
) (
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   // Command pins
   input  wire logic              chip_select_n_in,
   input  wire logic              write_enable_n_in,
   input  wire logic              maintenance_cmd_n_in,
   input  wire logic [BANK_W-1:0] bank_sel_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [MASK_W-1:0] byte_mask_in,
   // Decoded command to the array core
   output logic                   read_go_out,
   output logic                   write_go_out,
   output logic                   renew_go_out,
   output logic                   mode_go_out,
   output logic                   illegal_out,
   output logic      [BANK_W-1:0] cmd_bank_out,
   output logic      [ADDR_W-1:0] cmd_addr_out,
   // Write data timing
   output logic                   write_data_take_out,
   output logic      [MASK_W-1:0] write_keep_out,
   // Mode state
   output logic      [MODE_W-1:0] mode_reg_out,
   output logic      [3:0]        read_latency_out,
   output logic      [3:0]        write_latency_out,
   output logic      [3:0]        row_cycle_out,
   output logic      [1:0]        burst_len_code_out,
   output logic                   addr_mux_out,
   output logic                   align_loop_on_out,
   output logic                   align_locked_out,
   output logic                   mode_warn_out
);
   localparam int PIN_W = 3 + BANK_W + ADDR_W + MASK_W;

   // Synchronised pin bundle
   logic [PIN_W-1:0] pins_s;
   logic             cs_n;
   logic             we_n;
   logic             mt_n;
   logic [BANK_W-1:0] bank_s;
   logic [ADDR_W-1:0] addr_s;
   logic [MASK_W-1:0] mask_s;

   // Every pin crosses through two flops, so a command reaches the
   // outputs three edges after the controller drives it
   // pins sampled on rising edge
   dcd_sync #(
      .W (PIN_W)
   ) u_sync (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .d_in      ({chip_select_n_in, write_enable_n_in,
                   maintenance_cmd_n_in, bank_sel_in, addr_in,
                   byte_mask_in}),
      .q_out     (pins_s)
   );
   assign {cs_n, we_n, mt_n, bank_s, addr_s, mask_s} = pins_s;

   // Command decode
   dcd_cmd_t cmd;
   always_comb begin
      if (cs_n) begin
         cmd = CMD_IDLE;
      end else begin
         unique case ({we_n, mt_n})
            2'h0: cmd = CMD_MODE;
            2'h3: cmd = CMD_READ;
            2'h1: cmd = CMD_WRITE;
            2'h2: cmd = CMD_RENEW;
         endcase
      end
   end

   // Mode, address mux and align loop state
   logic [MODE_W-1:0] mode_ff, nxt_mode;
   logic              half_ff, nxt_half;      // Waiting for second half
   dcd_cmd_t          pend_ff, nxt_pend;      // Command awaiting half two
   logic [BANK_W-1:0] pbank_ff, nxt_pbank;
   logic [ADDR_W-1:0] paddr_ff, nxt_paddr;
   logic [LOCK_W-1:0] lock_ff, nxt_lock;
   logic              warn_ff, nxt_warn;
   // Decoded output registers
   logic rd_ff, nxt_rd, wr_ff, nxt_wr, rf_ff, nxt_rf, md_ff, nxt_md;
   logic bad_ff, nxt_bad;
   logic [BANK_W-1:0] obank_ff, nxt_obank;
   logic [ADDR_W-1:0] oaddr_ff, nxt_oaddr;
   // Write latency shift line, one tap per clock
   logic [15:0] wpipe_ff, nxt_wpipe;
   logic [MASK_W-1:0] keep_ff, nxt_keep;
   logic              take_ff, nxt_take;

   // Latency figures from current configuration
   logic [3:0] rlat, wlat, rcyc;
   logic       cfg_ok;
   dcd_latency u_lat (
      .cfg_in        (mode_ff[LAT_HI:LAT_LO]),
      .read_lat_out  (rlat),
      .write_lat_out (wlat),
      .row_cycle_out (rcyc),
      .cfg_ok_out    (cfg_ok)
   );

   // Checks a full mode word, flags unsupported combinations
   function automatic logic mode_bad(input logic [ADDR_W-1:0] a);
      logic [2:0] c;
      c = a[LAT_HI:LAT_LO];
      mode_bad = (a[MODE_W-1:ZERO_LO] != '0)
      // burst eight with config 1 or 4
               || (a[BL_HI:BL_LO] == BLC8 && (c == CFG1 || c == CFG4))
               || (a[BL_HI:BL_LO] == 2'h3) || (c > CFG5);
   endfunction

   // Next-state logic
   always_comb begin
      logic [ADDR_W-1:0] full_a;
      full_a    = '0;
      nxt_mode  = mode_ff;
      nxt_half  = 1'b0;
      nxt_pend  = pend_ff;
      nxt_pbank = pbank_ff;
      nxt_paddr = paddr_ff;
      nxt_warn  = warn_ff;
      nxt_rd    = 1'b0;
      nxt_wr    = 1'b0;
      nxt_rf    = 1'b0;
      nxt_md    = 1'b0;
      nxt_bad   = 1'b0;
      nxt_obank = obank_ff;
      nxt_oaddr = oaddr_ff;
      nxt_lock  = lock_ff;
      if (half_ff) begin
         // Chip select is not looked at here: the half is always next
         // second half completes address
         full_a    = {addr_s[ADDR_W/2-1:0], paddr_ff[ADDR_W/2-1:0]};
         nxt_obank = pbank_ff;
         nxt_oaddr = full_a;
         unique case (pend_ff)
            CMD_READ:  nxt_rd = 1'b1;
            CMD_WRITE: nxt_wr = 1'b1;
            default: begin
               nxt_md   = 1'b1;
               nxt_mode = full_a[MODE_W-1:0];
               nxt_warn = mode_bad(full_a);
            end
         endcase
      end else begin
         unique case (cmd)
            CMD_IDLE: ;
            CMD_RENEW: begin
               // renew bank only, address ignored
               // Renew has no second half, even with the address mux on
               nxt_rf    = 1'b1;
               nxt_obank = bank_s;
            end
            default: begin
               if (mode_ff[MUX_POS]) begin
                  nxt_half  = 1'b1;
                  nxt_pend  = cmd;
                  nxt_pbank = bank_s;
                  nxt_paddr = addr_s;
               end else if (cmd == CMD_MODE) begin
                  nxt_md   = 1'b1;
                  nxt_mode = addr_s[MODE_W-1:0];
                  nxt_warn = mode_bad(addr_s);
               end else begin
                  nxt_rd    = (cmd == CMD_READ);
                  nxt_wr    = (cmd == CMD_WRITE);
                  nxt_obank = bank_s;
                  nxt_oaddr = addr_s;
               end
            end
         endcase
      end
      // loop off while reset bit low; lock count restarts
      // The count stops at the target, so locked stays high
      if (!nxt_mode[ALIGN_POS]) begin
         nxt_lock = '0;
      end else if (lock_ff != LOCK_W'(LOCK_CLOCKS)) begin
         nxt_lock = lock_ff + LOCK_W'(1);
      end
   end

   // Write data window; taps one clock per stage
   // Sixteen taps cover the longest write latency of nine clocks
   always_comb begin
      nxt_wpipe = {wpipe_ff[14:0], wr_ff};
      nxt_take  = nxt_wpipe[wlat - 4'h1];
      nxt_keep  = ~mask_s;
   end

   // State registers
   // Reset puts every pulse low and the mode word at its default
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_ff  <= MODE_RST;
         half_ff  <= 1'b0;
         pend_ff  <= CMD_IDLE;
         pbank_ff <= '0;
         paddr_ff <= '0;
         lock_ff  <= '0;
         warn_ff  <= 1'b0;
         rd_ff    <= 1'b0;
         wr_ff    <= 1'b0;
         rf_ff    <= 1'b0;
         md_ff    <= 1'b0;
         bad_ff   <= 1'b0;
         obank_ff <= '0;
         oaddr_ff <= '0;
         wpipe_ff <= '0;
         keep_ff  <= '0;
         take_ff  <= 1'b0;
      end else begin
         mode_ff  <= nxt_mode;
         half_ff  <= nxt_half;
         pend_ff  <= nxt_pend;
         pbank_ff <= nxt_pbank;
         paddr_ff <= nxt_paddr;
         lock_ff  <= nxt_lock;
         warn_ff  <= nxt_warn;
         rd_ff    <= nxt_rd;
         wr_ff    <= nxt_wr;
         rf_ff    <= nxt_rf;
         md_ff    <= nxt_md;
         bad_ff   <= nxt_bad;
         obank_ff <= nxt_obank;
         oaddr_ff <= nxt_oaddr;
         wpipe_ff <= nxt_wpipe;
         keep_ff  <= nxt_keep;
         take_ff  <= nxt_take;
      end
   end

   // Outputs from registers; latency figures and warning decoded from them
   assign read_go_out         = rd_ff;
   assign write_go_out        = wr_ff;
   assign renew_go_out        = rf_ff;
   assign mode_go_out         = md_ff;
   // Every pin pair is defined, so this stays low; a bad mode word shows on mode_warn_out
   assign illegal_out         = bad_ff;
   assign cmd_bank_out        = obank_ff;
   assign cmd_addr_out        = oaddr_ff;
   assign write_data_take_out = take_ff;
   assign write_keep_out      = keep_ff;
   assign mode_reg_out        = mode_ff;
   assign read_latency_out    = rlat;
   assign write_latency_out   = wlat;
   assign row_cycle_out       = rcyc;
   // no stored data is guarded across a burst change
   // the core only sees the new code
   // burst code steers used address width
   assign burst_len_code_out  = mode_ff[BL_HI:BL_LO];
   assign addr_mux_out        = mode_ff[MUX_POS];
   // loop runs only with reset bit high
   assign align_loop_on_out   = mode_ff[ALIGN_POS];
   assign align_locked_out    = (lock_ff == LOCK_W'(LOCK_CLOCKS));
   // A reserved configuration warns even between loads
   assign mode_warn_out       = warn_ff | ~cfg_ok;

   // Elaboration checks: the lock counter must hold the full count
   if (LOCK_CLOCKS < 1) begin
      $error("LOCK_CLOCKS must be positive");
   end
   if (LOCK_CLOCKS >= (1 << LOCK_W)) begin
      $error("LOCK_CLOCKS does not fit the lock counter");
   end
endmodule
`default_nettype wire

// ==== verilog/dcd_pkg.sv ====
// Constants shared by the command decoder and its helpers.
// Assumes one 20 MHz clock and an active-low asynchronous reset.
`default_nettype none
package dcd_pkg;
   // Pin and field widths
   localparam int ADDR_W      = 22;
   localparam int BANK_W      = 3;
   localparam int MODE_W      = 18;
   localparam int MASK_W      = 2;
   // Mode field positions
   localparam int LAT_LO      = 0;
   localparam int LAT_HI      = 2;
   localparam int BL_LO       = 3;
   localparam int BL_HI       = 4;
   localparam int MUX_POS     = 5;
   localparam int ALIGN_POS   = 7;
   localparam int ZERO_LO     = 10;
   // Mode register reset value: align loop reset low, loop off
   localparam logic [17:0] MODE_RST = 18'h00000;
   // Latency configuration codes
   localparam logic [2:0] CFG1 = 3'h0;
   localparam logic [2:0] CFG2 = 3'h1;
   localparam logic [2:0] CFG3 = 3'h2;
   localparam logic [2:0] CFG4 = 3'h3;
   localparam logic [2:0] CFG5 = 3'h4;
   // Read latency per configuration, in clocks
   localparam logic [3:0] RLAT1 = 4'h4;
   localparam logic [3:0] RLAT2 = 4'h6;
   localparam logic [3:0] RLAT3 = 4'h8;
   localparam logic [3:0] RLAT4 = 4'h3;
   localparam logic [3:0] RLAT5 = 4'h5;
   // Burst length codes
   localparam logic [1:0] BLC2 = 2'h0;
   localparam logic [1:0] BLC4 = 2'h1;
   localparam logic [1:0] BLC8 = 2'h2;
   // Align loop lock time in clocks
   localparam int LOCK_CYC    = 1024;
   localparam int LOCK_W      = 11;
   // Decoded command kinds
   typedef enum logic [2:0] {
      CMD_IDLE, CMD_MODE, CMD_READ, CMD_WRITE, CMD_RENEW, CMD_BAD
   } dcd_cmd_t;
endpackage
`default_nettype wire

// ==== verilog/dcd_sync.sv ====
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the pins are asynchronous to clock_in.
`default_nettype none
module dcd_sync
   import dcd_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock_in,
   input  wire logic         resetn_in,
   // Pin side and synchronised side
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_ff;   // First stage, read only by second
   logic [W-1:0] q_ff;      // Second stage
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_q;

   // Next values: shift through two stages
   always_comb begin
      nxt_meta = d_in;
      nxt_q    = meta_ff;
   end

   // Registers; reset to ones so active-low pins read inactive
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_ff <= '1;
         q_ff    <= '1;
      end else begin
         meta_ff <= nxt_meta;
         q_ff    <= nxt_q;
      end
   end

   assign q_out = q_ff;

   // Elaboration check: an empty bus cannot be synchronised
   if (W < 1) begin
      $error("dcd_sync width must be positive");
   end
endmodule
`default_nettype wire

// ==== verilog/dcd_latency.sv ====
// Latency table: maps the configuration code to cycle figures.
// Purely combinational; the caller drives its latency ports straight from the results and ORs the inverse of cfg_ok into its warning.
`default_nettype none
module dcd_latency
   import dcd_pkg::*;
(
   // Configuration in
   input  wire logic [2:0] cfg_in,
   // Figures out
   output logic      [3:0] read_lat_out,
   output logic      [3:0] write_lat_out,
   output logic      [3:0] row_cycle_out,
   output logic            cfg_ok_out
);
   // Table lookup
   always_comb begin
      cfg_ok_out   = 1'b1;
      read_lat_out = RLAT1;
      unique case (cfg_in)
         CFG1: read_lat_out = RLAT1;
         CFG2: read_lat_out = RLAT2;
         CFG3: read_lat_out = RLAT3;
         CFG4: read_lat_out = RLAT4;
         CFG5: read_lat_out = RLAT5;
         // Reserved codes fall back to the slowest safe figure
         default: begin
            read_lat_out = RLAT3;
            cfg_ok_out   = 1'b0;
         end
      endcase
      // Row cycle equals read latency in every configuration
      row_cycle_out = read_lat_out;
      write_lat_out = read_lat_out + 4'h1;
   end
endmodule
`default_nettype wire

// ==== bench/dcd_ctrl_model.sv ====
// Behavioural memory controller that drives the decoder's command pins.
// Assumes the bench calls send and deselect; the waits keep its timing.
`default_nettype none
module dcd_ctrl_model
   import dcd_pkg::*;
#(
   parameter int SETTLE = 8,  // Mode settle time, plain default
   parameter int RC_MAX = 9,  // Longest row cycle plus write-read clock
   parameter int LOCK   = 8   // Align loop lock wait
) (
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   // Command pins toward the decoder
   output logic                   chip_select_n_in,
   output logic                   write_enable_n_in,
   output logic                   maintenance_cmd_n_in,
   output logic      [BANK_W-1:0] bank_sel_in,
   output logic      [ADDR_W-1:0] addr_in,
   output logic      [MASK_W-1:0] byte_mask_in
);
   timeunit 1ns;
   timeprecision 1ns;
   int cyc = 0;       // Clock count for the wait rules
   int free_at [8];   // Cycle at which each bank may be used again
   int quiet_at = 0;  // End of mode settle time
   int lock_at = 0;   // End of align loop lock wait
   bit mux = 1'b0;    // Addresses go in two halves

   // Free-running cycle count
   always @(posedge clock_in) cyc <= cyc + 1;

   // Pins start deselected
   initial begin
      chip_select_n_in = 1'b1;
      write_enable_n_in = 1'b1;
      maintenance_cmd_n_in = 1'b1;
      bank_sel_in = '0;
      addr_in = '0;
      byte_mask_in = '0;
   end

   // One command; a deselect (idle) puts a[1:0] on the pair as noise
   task automatic send(input dcd_cmd_t k, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a,
                       input logic [MASK_W-1:0] m);
      int t;
      t = quiet_at;
      if (k == CMD_READ && lock_at > t)
         t = lock_at;
      foreach (free_at[i])
         if ((k == CMD_MODE || i == b) && free_at[i] > t)
            t = free_at[i];
      @(posedge clock_in);
      // Release the pins while waiting, so a held command never repeats
      while (cyc < t) begin
         chip_select_n_in <= 1'b1;
         bank_sel_in <= ~bank_sel_in;
         addr_in <= ~addr_in;
         @(posedge clock_in);
      end
      chip_select_n_in <= (k == CMD_IDLE);
      write_enable_n_in <= (k == CMD_IDLE) ? a[0] :
                           !(k == CMD_MODE || k == CMD_WRITE);
      maintenance_cmd_n_in <= (k == CMD_IDLE) ? a[1] :
                              !(k == CMD_MODE || k == CMD_RENEW);
      bank_sel_in <= b;
      addr_in <= a;
      byte_mask_in <= m;
      // worst row cycle on the bank
      if (k != CMD_IDLE && k != CMD_MODE)
         free_at[b] = cyc + RC_MAX;
      // Second half next edge, chip deselected
      if (mux && k != CMD_IDLE && k != CMD_RENEW) begin
         @(posedge clock_in);
         chip_select_n_in <= 1'b1;
         addr_in <= {~a[21:11], a[21:11]};
      end
      // caller keeps upper mode bits zero
      if (k == CMD_MODE) begin
         quiet_at = cyc + SETTLE;
         mux = a[MUX_POS];
         if (a[ALIGN_POS])
            lock_at = cyc + SETTLE + LOCK;
      end
   endtask

   // Release: lines no longer hold their last value
   task automatic deselect();
      @(posedge clock_in);
      chip_select_n_in <= 1'b1;
      bank_sel_in <= ~bank_sel_in;
      addr_in <= ~addr_in;
   endtask
endmodule
`default_nettype wire

// ==== bench/dcd_decoder_asserts.sv ====
// Port-level checker for the command decoder.
// Assumes the two-flop pin synchroniser: pins show up 3 clocks later.
`default_nettype none
module dcd_asserts
   import dcd_pkg::*;
#(
   parameter int LOCK_CLOCKS = LOCK_CYC
) (
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   input  wire logic              chip_select_n_in,
   input  wire logic              write_enable_n_in,
   input  wire logic              maintenance_cmd_n_in,
   input  wire logic [BANK_W-1:0] bank_sel_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [MASK_W-1:0] byte_mask_in,
   input  wire logic              read_go_out,
   input  wire logic              write_go_out,
   input  wire logic              renew_go_out,
   input  wire logic              mode_go_out,
   input  wire logic              illegal_out,
   input  wire logic [BANK_W-1:0] cmd_bank_out,
   input  wire logic [ADDR_W-1:0] cmd_addr_out,
   input  wire logic              write_data_take_out,
   input  wire logic [MASK_W-1:0] write_keep_out,
   input  wire logic [MODE_W-1:0] mode_reg_out,
   input  wire logic [3:0]        read_latency_out,
   input  wire logic [3:0]        write_latency_out,
   input  wire logic [1:0]        burst_len_code_out,
   input  wire logic              addr_mux_out,
   input  wire logic              align_loop_on_out,
   input  wire logic              align_locked_out
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PW = BANK_W + ADDR_W + MASK_W;
   logic [2:0]        c1_ff, c2_ff, c3_ff;  // Pin triple history
   logic [PW-1:0]     p1_ff, p2_ff, p3_ff;  // Bank, address, mask
   logic [MODE_W-1:0] mlat_ff;              // Last mode word decoded
   wire logic quiet = !addr_mux_out;        // Halves shift the timing
   wire logic [ADDR_W-1:0] addr3 = p3_ff[MASK_W +: ADDR_W];

   // History resets to idle, as the real synchroniser does
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {c1_ff, c2_ff, c3_ff} <= '1;
         {p1_ff, p2_ff, p3_ff} <= '0;
         mlat_ff <= '0;
      end else begin
         c1_ff <= {chip_select_n_in, write_enable_n_in,
                   maintenance_cmd_n_in};
         p1_ff <= {bank_sel_in, addr_in, byte_mask_in};
         {c3_ff, c2_ff} <= {c2_ff, c1_ff};
         {p3_ff, p2_ff} <= {p2_ff, p1_ff};
         if (c3_ff == 3'h0)
            mlat_ff <= addr3[MODE_W-1:0];
      end
   end

   default clocking dcb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   property p_read; quiet |-> read_go_out == (c3_ff == 3'h3); endproperty
   a_read: assert property (p_read)
      else $error("read pulse wrong");
   property p_write; quiet |-> write_go_out == (c3_ff == 3'h1); endproperty
   a_write: assert property (p_write)
      else $error("write pulse wrong");
   property p_renew; quiet |-> renew_go_out == (c3_ff == 3'h2); endproperty
   a_renew: assert property (p_renew)
      else $error("renew pulse wrong");
   property p_mode; quiet |-> mode_go_out == (c3_ff == 3'h0); endproperty
   a_mode: assert property (p_mode)
      else $error("mode pulse wrong");
   property p_desel;
      quiet && c3_ff[2] |-> !(read_go_out || write_go_out ||
                              renew_go_out || mode_go_out);
   endproperty
   a_desel: assert property (p_desel)
      else $error("command while deselected");
   property p_illegal; illegal_out == 1'b0; endproperty
   a_illegal: assert property (p_illegal)
      else $error("defined command flagged");
   property p_addr;
      quiet && (read_go_out || write_go_out) |->
         cmd_bank_out == p3_ff[PW-1 -: BANK_W] && cmd_addr_out == addr3;
   endproperty
   a_addr: assert property (p_addr)
      else $error("bank or address wrong");
   property p_keep;
      quiet && write_go_out |-> write_keep_out == ~p3_ff[MASK_W-1:0];
   endproperty
   a_keep: assert property (p_keep)
      else $error("byte keep wrong");
   property p_take; write_go_out |-> ##[4:9] write_data_take_out;
   endproperty
   a_take: assert property (p_take)
      else $error("write data never taken");
   property p_mcap; quiet && mode_go_out |=> mode_reg_out == mlat_ff;
   endproperty
   a_mcap: assert property (p_mcap)
      else $error("mode word not captured");
   property p_wlat; write_latency_out == read_latency_out + 4'h1;
   endproperty
   a_wlat: assert property (p_wlat)
      else $error("write latency not read plus one");
   property p_fields;
      burst_len_code_out == mode_reg_out[BL_HI:BL_LO] &&
      addr_mux_out == mode_reg_out[MUX_POS] &&
      align_loop_on_out == mode_reg_out[ALIGN_POS];
   endproperty
   a_fields: assert property (p_fields)
      else $error("mode field outputs wrong");
   property p_lock; $rose(align_loop_on_out) |-> !align_locked_out [*4];
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked too early");
   property p_off; !align_loop_on_out |-> !align_locked_out; endproperty
   a_off: assert property (p_off)
      else $error("locked while loop off");
endmodule
bind dcd_decoder dcd_asserts #(.LOCK_CLOCKS(LOCK_CLOCKS)) dcd_asserts_inst
   (.*);
`default_nettype wire

// ==== bench/dcd_decoder_tb_top.sv ====
// Self-checking bench for the command decoder.
// Assumes the controller model drives every command pin.
`default_nettype none
module dcd_decoder_tb_top
   import dcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LOCKN = 8;  // Short lock count for simulation
   typedef struct {dcd_cmd_t k; logic [2:0] b; logic [21:0] a;} dcd_exp_t;
   logic              clock_in = 1'b0;
   logic              resetn_in = 1'b0;
   logic              chip_select_n_in, write_enable_n_in;
   logic              maintenance_cmd_n_in;
   logic [BANK_W-1:0] bank_sel_in, cmd_bank_out;
   logic [ADDR_W-1:0] addr_in, cmd_addr_out, mw;
   logic [MASK_W-1:0] byte_mask_in, write_keep_out;
   logic              read_go_out, write_go_out, renew_go_out, mode_go_out;
   logic              illegal_out, write_data_take_out, addr_mux_out;
   logic              align_loop_on_out, align_locked_out, mode_warn_out;
   logic [MODE_W-1:0] mode_reg_out;
   logic [3:0]        read_latency_out, write_latency_out, row_cycle_out;
   logic [1:0]        burst_len_code_out;
   logic [31:0]       seed = 32'h47ce3821, r;
   logic [3:0]        rlat [5] = '{RLAT1, RLAT2, RLAT3, RLAT4, RLAT5};
   dcd_cmd_t          kinds [4] = '{CMD_IDLE, CMD_READ, CMD_WRITE, CMD_RENEW};
   dcd_exp_t          expq [$], e;
   int                num_errors = 0, tests_run = 0;

   dcd_decoder #(.LOCK_CLOCKS(LOCKN)) dcd_decoder_inst (.*);
   dcd_ctrl_model #(.LOCK(LOCKN)) dcd_ctrl_model_inst (.*);

   // 20 MHz clock
   always #25 clock_in = ~clock_in;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Issue a command and note what should come out
   task automatic go(input dcd_cmd_t k, input logic [2:0] b,
                     input logic [21:0] a, input logic [1:0] m);
      if (k != CMD_IDLE)
         expq.push_back('{k, b, a});
      dcd_ctrl_model_inst.send(k, b, a, m);
   endtask

   // Each decoded pulse takes the oldest note; an unknown counts too
   always @(posedge clock_in) begin
      if ((read_go_out | write_go_out | renew_go_out | mode_go_out) !== 0)
      begin
         if (expq.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            e = expq.pop_front();
            check({read_go_out, write_go_out, renew_go_out, mode_go_out},
                  {e.k == CMD_READ, e.k == CMD_WRITE, e.k == CMD_RENEW,
                   e.k == CMD_MODE});
            if (e.k != CMD_MODE)
               check(cmd_bank_out, e.b);
            if (e.k == CMD_READ || e.k == CMD_WRITE)
               check(cmd_addr_out, e.a);
         end
      end
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge clock_in);
      resetn_in <= 1'b1;
      check(mode_reg_out, 32'h0);
      check(write_latency_out, 32'h5);
      $display("reset values done");
      for (logic [2:0] c = 0; c < 5; c++) begin
         for (logic [1:0] l = 0; l < 3; l++) begin
            // no burst of eight in configs one, four
            if (l == 2 && (c == 0 || c == 3))
               continue;
            r = rnd();
            mw = {12'h0, r[1:0], 1'b0, r[2], 1'b0, l, c};
            go(CMD_MODE, r[5:3], mw, r[7:6]);
            dcd_ctrl_model_inst.deselect();
            repeat (8) @(posedge clock_in);
            check(mode_reg_out, mw);
            check(read_latency_out, rlat[c]);
            check(row_cycle_out, rlat[c]);
            check(write_latency_out, rlat[c] + 4'h1);
            check(burst_len_code_out, l);
            check(mode_warn_out, 32'h0);
         end
      end
      $display("mode configurations done");
      go(CMD_MODE, 3'h0, 22'h81, 2'h0);
      dcd_ctrl_model_inst.deselect();
      repeat (6) @(posedge clock_in);
      check(align_loop_on_out, 32'h1);
      check(align_locked_out, 32'h0);
      repeat (12) @(posedge clock_in);
      check(align_locked_out, 32'h1);
      $display("align loop done");
      for (int i = 0; i < 64; i++) begin
         r = rnd();
         go(kinds[r[1:0]], r[4:2], 22'(rnd()), r[6:5]);
         if (r[7])
            dcd_ctrl_model_inst.deselect();
      end
      dcd_ctrl_model_inst.deselect();
      $display("random traffic done");
      go(CMD_MODE, 3'h0, 22'ha1, 2'h0);
      for (int i = 0; i < 9; i++) begin
         r = rnd();
         go(kinds[1 + i % 3], r[2:0], 22'(rnd()), r[4:3]);
      end
      dcd_ctrl_model_inst.deselect();
      for (int w = 0; w < 60 && expq.size() != 0; w++)
         @(posedge clock_in);
      check(32'(expq.size()), 32'h0);
      $display("address halves done");
      tally_and_finish();
   end

   // The run needs a few hundred clocks; far beyond that is a hang
   initial begin
      #(50 * 20000);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
